// ==== design/pxrw_regs.v ====
// APB register bank for the eight-lane controller address windows
// Behaviour
// - start bit 0 set marks the window valid; clear means no region.
// - start bits 28:1 hold base address bits 47:20, read/write.
// - start bit 29 set: non-secure, admit all; clear: secure traffic only.
// - end bits 27:0 hold limit bits 47:20; bits 31:28 read zero.
// - every register is 32 bits and always present.
// - first config space window end at 0x204.
// - low io window start 0x208, end 0x20C.
// - high io window start 0x210, end 0x214.
// - remap window start 0x218, end 0x21C.
// - config window start at 0x220, same layout as other starts.
// - first config space window start at 0x200.
`timescale 1ns/1ps
`default_nettype none
`include "pxrw_consts.vh"

module pxrw_regs #(
  parameter NWIN = 5
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // transaction to filter, same clock domain
  input wire [47:0] txn_addr,
  input wire txn_secure,
  // window decode results, registered
  output reg [NWIN-1:0] win_hit_q,
  output reg [NWIN-1:0] win_allow_q,
  output reg txn_block_q,
  // decoded window values
  output reg [NWIN-1:0] win_valid_q,
  output reg [NWIN-1:0] win_secdis_q,
  output reg [NWIN*28-1:0] win_base_q,
  output reg [NWIN*28-1:0] win_limit_q
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // window order: 0 first config space, 1 low io, 2 high io, 3 remap, 4 config
  // config window end lies outside this bank, its limit is all ones
  function [11:0] start_off;
    input integer i;
    begin
      case (i)
        0: start_off = `PXRW_OFF_CFGSP_START;
        1: start_off = `PXRW_OFF_LOWIO_START;
        2: start_off = `PXRW_OFF_HIGHIO_START;
        3: start_off = `PXRW_OFF_REMAP_START;
        default: start_off = `PXRW_OFF_CFGWIN_START;
      endcase
    end
  endfunction

  function [11:0] end_off;
    input integer i;
    begin
      case (i)
        0: end_off = `PXRW_OFF_CFGSP_END;
        1: end_off = `PXRW_OFF_LOWIO_END;
        2: end_off = `PXRW_OFF_HIGHIO_END;
        default: end_off = `PXRW_OFF_REMAP_END;
      endcase
    end
  endfunction

  // byte-lane merge of a write into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // full 32-bit words, no configuration removes them
  reg [31:0] start_q [0:NWIN-1];
  reg [31:0] end_q [0:NWIN-1];

  wire wr_en;
  wire rd_en;
  wire [NWIN-1:0] g_hits;
  wire [NWIN-1:0] g_allows;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  genvar g;
  generate
    for (g = 0; g < NWIN; g = g + 1) begin : g_win
      wire start_sel;
      wire end_sel;
      assign start_sel = (paddr == start_off(g));
      assign end_sel = (g < NWIN - 1) && (paddr == end_off(g));
      wire start_we;
      wire end_we;
      assign start_we = wr_en && start_sel;
      assign end_we = wr_en && end_sel;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          start_q[g] <= `PXRW_START_RESET;
        end else if (start_we) begin
          start_q[g] <= merge(start_q[g], pwdata, pstrb) & `PXRW_START_WMASK;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          end_q[g] <= `PXRW_END_RESET;
        end else if (end_we) begin
          end_q[g] <= merge(end_q[g], pwdata, pstrb) & `PXRW_END_WMASK;
        end
      end

      // ----------------------------------------
      // window slices
      // ----------------------------------------
      // decoded fields for the address decoder
      wire w_valid;
      wire w_secdis;
      wire [27:0] w_base;
      wire [27:0] w_limit;
      assign w_valid = start_q[g][`PXRW_START_VALID_BIT];
      assign w_secdis = start_q[g][`PXRW_START_SECDIS_BIT];
      assign w_base = start_q[g][`PXRW_START_BASE_MSB:`PXRW_START_BASE_LSB];
      assign w_limit = (g < NWIN - 1) ?
        end_q[g][`PXRW_END_LIMIT_MSB:`PXRW_END_LIMIT_LSB] : 28'hFFFFFFF;

      // ----------------------------------------
      // window filter
      // ----------------------------------------
      wire m_hit;
      wire m_allow;
      pxrw_match u_match (
        .valid(w_valid),
        .sec_dis(w_secdis),
        .base(w_base),
        .limit(w_limit),
        .addr(txn_addr[47:20]),
        .secure(txn_secure),
        .hit(m_hit),
        .allow(m_allow)
      );
      assign g_hits[g] = m_hit;
      assign g_allows[g] = m_allow;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          win_hit_q[g] <= 1'b0;
          win_allow_q[g] <= 1'b0;
        end else begin
          win_hit_q[g] <= m_hit;
          win_allow_q[g] <= m_allow;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          win_valid_q[g] <= 1'b0;
          win_secdis_q[g] <= 1'b0;
        end else begin
          win_valid_q[g] <= w_valid;
          win_secdis_q[g] <= w_secdis;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          win_base_q[g*28 +: 28] <= 28'h0000000;
          win_limit_q[g*28 +: 28] <= 28'h0000000;
        end else begin
          win_base_q[g*28 +: 28] <= w_base;
          win_limit_q[g*28 +: 28] <= w_limit;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // status and blocking
  // ----------------------------------------
  // a transaction inside some valid window but admitted by none is blocked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txn_block_q <= 1'b0;
    end else begin
      txn_block_q <= (|g_hits) && !(|g_allows);
    end
  end

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // ready from a flop held high: every access ends in its first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b1;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [31:0] rd_d;
  reg hit_d;
  always @* begin
    rd_d = 32'h00000000;
    hit_d = 1'b0;
    case (paddr)
      `PXRW_OFF_CFGSP_START: begin
        rd_d = start_q[0];
        hit_d = 1'b1;
      end
      `PXRW_OFF_CFGSP_END: begin
        rd_d = end_q[0];
        hit_d = 1'b1;
      end
      `PXRW_OFF_LOWIO_START: begin
        rd_d = start_q[1];
        hit_d = 1'b1;
      end
      `PXRW_OFF_LOWIO_END: begin
        rd_d = end_q[1];
        hit_d = 1'b1;
      end
      `PXRW_OFF_HIGHIO_START: begin
        rd_d = start_q[2];
        hit_d = 1'b1;
      end
      `PXRW_OFF_HIGHIO_END: begin
        rd_d = end_q[2];
        hit_d = 1'b1;
      end
      `PXRW_OFF_REMAP_START: begin
        rd_d = start_q[3];
        hit_d = 1'b1;
      end
      `PXRW_OFF_REMAP_END: begin
        rd_d = end_q[3];
        hit_d = 1'b1;
      end
      `PXRW_OFF_CFGWIN_START: begin
        rd_d = start_q[4];
        hit_d = 1'b1;
      end
      // status shows the latest decode result, read only
      `PXRW_OFF_STATUS: begin
        rd_d = {
          15'h0000,
          txn_block_q,
          3'b000,
          win_allow_q,
          3'b000,
          win_hit_q
        };
        hit_d = 1'b1;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // response
  // ----------------------------------------
  // unmapped address: read zero, writes dropped, pslverr raised
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !hit_d;
    end
  end

  wire unused_rd;
  assign unused_rd = rd_en;

endmodule // pxrw_regs

`default_nettype wire

// ==== common/pxrw_consts.vh ====
// register offsets, field positions and reset values of the eight-lane window bank
`ifndef PXRW_CONSTS_VH
`define PXRW_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PXRW_OFF_CFGSP_START 12'h200
`define PXRW_OFF_CFGSP_END 12'h204
`define PXRW_OFF_LOWIO_START 12'h208
`define PXRW_OFF_LOWIO_END 12'h20C
`define PXRW_OFF_HIGHIO_START 12'h210
`define PXRW_OFF_HIGHIO_END 12'h214
`define PXRW_OFF_REMAP_START 12'h218
`define PXRW_OFF_REMAP_END 12'h21C
`define PXRW_OFF_CFGWIN_START 12'h220
`define PXRW_OFF_STATUS 12'h240

// ----------------------------------------
// start register fields
// ----------------------------------------
`define PXRW_START_VALID_BIT 0
`define PXRW_START_BASE_LSB 1
`define PXRW_START_BASE_MSB 28
`define PXRW_START_SECDIS_BIT 29
`define PXRW_START_WMASK 32'h3FFFFFFF

// ----------------------------------------
// end register fields
// ----------------------------------------
`define PXRW_END_LIMIT_LSB 0
`define PXRW_END_LIMIT_MSB 27
`define PXRW_END_WMASK 32'h0FFFFFFF

// ----------------------------------------
// reset values
// ----------------------------------------
`define PXRW_START_RESET 32'h00000000
`define PXRW_END_RESET 32'h00000000

`endif

// ==== design/pxrw_match.v ====
// one address window comparator with valid and security filtering
`timescale 1ns/1ps
`default_nettype none

module pxrw_match (
  // window programming
  input wire valid,
  input wire sec_dis,
  input wire [27:0] base,
  input wire [27:0] limit,
  // transaction
  input wire [27:0] addr,
  input wire secure,
  // result
  output wire hit,
  output wire allow
);

  assign hit = valid && (addr >= base) && (addr <= limit);
  // secure window admits only secure traffic
  assign allow = hit && (sec_dis || secure);

endmodule // pxrw_match

`default_nettype wire

// ==== verif/pxrw_regs_asserts.sv ====
// concurrent checks on the window register bank ports
`timescale 1ns/1ps
`default_nettype none
module pxrw_regs_asserts #(parameter NWIN = 5) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // filter
  input wire [47:0] txn_addr,
  input wire txn_secure,
  input wire [NWIN-1:0] win_hit_q,
  input wire [NWIN-1:0] win_allow_q,
  input wire txn_block_q,
  input wire [NWIN-1:0] win_valid_q,
  input wire [NWIN-1:0] win_secdis_q,
  input wire [NWIN*28-1:0] win_base_q,
  input wire [NWIN*28-1:0] win_limit_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the low io start register; decoded copy lags writes by up to two edges
  logic [31:0] lw_q;
  logic wr_q;
  logic wr2_q;
  wire acc = psel && penable;
  wire rd_win = acc && !pwrite && paddr[11:5] == 7'h10 && paddr[1:0] == 2'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lw_q <= 32'h0;
      wr_q <= 1'h0;
      wr2_q <= 1'h0;
    end else begin
      if (acc && pwrite && paddr == 12'h208 && pstrb == 4'hF) lw_q <= pwdata;
      wr_q <= acc && pwrite;
      wr2_q <= wr_q;
    end
  end
  ready_high_a: assert property (pready) else $error("ready low");
  unmapped_err_a: assert property (acc && !pwrite && paddr == 12'h3FC |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (rd_win |-> !pslverr) else $error("mapped read refused");
  start_rsv_a: assert property (rd_win && !paddr[2] |-> prdata[31:30] == 2'h0)
    else $error("start reserved bits set");
  end_rsv_a: assert property (rd_win && paddr[2] |-> prdata[31:28] == 4'h0)
    else $error("end reserved bits set");
  lowio_decode_a: assert property (!wr_q && !wr2_q |-> win_valid_q[1] == lw_q[0] &&
    win_base_q[55:28] == lw_q[28:1] && win_secdis_q[1] == lw_q[29]) else $error("decode wrong");
  hit_rel_a: assert property (!wr_q && !wr2_q |-> win_hit_q[1] == ($past(win_valid_q[1]) &&
    $past(txn_addr[47:20]) >= $past(win_base_q[55:28]) &&
    $past(txn_addr[47:20]) <= $past(win_limit_q[55:28]))) else $error("hit wrong");
  allow_rel_a: assert property (!wr_q && !wr2_q |-> win_allow_q ==
    (win_hit_q & ($past(win_secdis_q) | {NWIN{$past(txn_secure)}}))) else $error("allow wrong");
  block_rel_a: assert property (txn_block_q == (|win_hit_q && !(|win_allow_q)))
    else $error("block wrong");
endmodule // pxrw_regs_asserts
bind pxrw_regs pxrw_regs_asserts #(.NWIN(NWIN)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txn_addr(txn_addr),
  .txn_secure(txn_secure), .win_hit_q(win_hit_q), .win_allow_q(win_allow_q),
  .txn_block_q(txn_block_q), .win_valid_q(win_valid_q), .win_secdis_q(win_secdis_q),
  .win_base_q(win_base_q), .win_limit_q(win_limit_q));
`default_nettype wire

// ==== verif/pxrw_txn_src.sv ====
// far-side model: interconnect launching transactions into the window filter
`timescale 1ns/1ps
`default_nettype none
module pxrw_txn_src (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic [47:0] req_addr,
  input wire logic req_secure,
  // transaction to the filter
  output logic [47:0] txn_addr,
  output logic txn_secure
);
  // launched from a flop, so the filter never sees a bench edge race
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txn_addr <= 48'h0;
      txn_secure <= 1'h0;
    end else begin
      txn_addr <= req_addr;
      txn_secure <= req_secure;
    end
  end
endmodule // pxrw_txn_src
`default_nettype wire

// ==== verif/pcie_x8_region_window_regs_tb.sv ====
// self-checking bench for the eight-lane window register bank
`timescale 1ns/1ps
`default_nettype none
`include "pxrw_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pcie_x8_region_window_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, req_sec, tsec, blk;
  logic [11:0] paddr;
  logic [3:0] strb;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] req_addr, taddr;
  logic [4:0] hit, allow, vld, sd;
  logic [139:0] base, lim;
  int mismatches, total_checks;
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  pxrw_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txn_addr(taddr), .txn_secure(tsec),
    .win_hit_q(hit), .win_allow_q(allow), .txn_block_q(blk), .win_valid_q(vld),
    .win_secdis_q(sd), .win_base_q(base), .win_limit_q(lim));
  pxrw_txn_src u_src (.pclk(pclk), .presetn(presetn), .req_addr(req_addr),
    .req_secure(req_sec), .txn_addr(taddr), .txn_secure(tsec));
  // one apb transfer, then an idle edge so psel is never reassigned in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 9; i++) begin
      apb(1'h0, 12'h200 + 12'(4 * i), 32'h0);
      `CHK(rd, 32'h0)
    end
    $display("reset values done");
  endtask
  task automatic t_rw();
    for (int i = 0; i < 9; i++) begin
      apb(1'h1, 12'h200 + 12'(4 * i), 32'hFFFFFFFF);
      apb(1'h0, 12'h200 + 12'(4 * i), 32'h0);
      `CHK(rd, i[0] ? `PXRW_END_WMASK : `PXRW_START_WMASK)
      `CHK(er, 1'h0)
      apb(1'h1, 12'h200 + 12'(4 * i), 32'h0);
    end
    // only the two low byte lanes are written
    strb <= 4'h3;
    apb(1'h1, `PXRW_OFF_HIGHIO_END, 32'hFFFFFFFF);
    strb <= 4'hF;
    apb(1'h0, `PXRW_OFF_HIGHIO_END, 32'h0);
    `CHK(rd, 32'h0000FFFF)
    apb(1'h1, `PXRW_OFF_HIGHIO_END, 32'h0);
    $display("read write done");
  endtask
  task automatic t_unmap();
    apb(1'h1, 12'h3FC, 32'hFFFFFFFF);
    apb(1'h0, 12'h3FC, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'h0, 12'h208, 32'h0);
    `CHK(rd, 32'h0)
    $display("unmapped done");
  endtask
  // the model and the filter each add one edge before the result shows
  task automatic probe(input logic [27:0] a, input logic s, input logic h, input logic al);
    req_addr <= {a, 20'h5A5A5};
    req_sec <= s;
    repeat (3) @(posedge pclk);
    #1;
    `CHK(hit, {3'h0, h, 1'h0})
    `CHK(allow, {3'h0, al, 1'h0})
    `CHK(blk, h & ~al)
    @(posedge pclk);
  endtask
  task automatic t_match();
    apb(1'h1, 12'h20C, 32'h20);
    apb(1'h1, 12'h208, 32'h21);
    probe(28'h10, 1'h0, 1'h1, 1'h0);
    // status: hit in bits 4:0, allow in 12:8, block in 16
    apb(1'h0, `PXRW_OFF_STATUS, 32'h0);
    `CHK(rd, 32'h00010002)
    probe(28'h10, 1'h1, 1'h1, 1'h1);
    probe(28'hF, 1'h1, 1'h0, 1'h0);
    probe(28'h20, 1'h1, 1'h1, 1'h1);
    probe(28'h21, 1'h1, 1'h0, 1'h0);
    apb(1'h1, 12'h208, 32'h20000021);
    probe(28'h15, 1'h0, 1'h1, 1'h1);
    apb(1'h1, 12'h208, 32'h20000020);
    probe(28'h15, 1'h1, 1'h0, 1'h0);
    $display("window match done");
  endtask
  task automatic t_rst2();
    apb(1'h1, `PXRW_OFF_HIGHIO_START, 32'h3FFFFFFF);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, `PXRW_OFF_HIGHIO_START, 32'h0);
    `CHK(rd, 32'h0)
    $display("mid-run reset done");
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h0; pwdata = 32'h0; req_addr = 48'h0; req_sec = 1'h0; strb = 4'hF;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_rw();
    t_unmap();
    t_match();
    t_rst2();
    tally_and_finish();
  end
  // hang guard, well beyond the roughly 180 edges the tests need
  initial begin
    repeat (3000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end
endmodule // pcie_x8_region_window_regs_tb
`default_nettype wire
